//--- verilog/tmr_pkg.sv
// Purpose: shared constants for the timer prescaler and event/interrupt block
// Assumes: single clock domain, clock clk_i at 125 MHz
// Notes:   prescale codes ascend from 1:1 to 1:256
package tmr_pkg;

  // ----------------------------------------------------------------
  // prescale selection
  // ----------------------------------------------------------------
  localparam int unsigned PSC_SEL_W    = 3;                // prescale_select width
  localparam int unsigned PSC_CNT_W    = 8;                // prescale counter width
  localparam logic [7:0]  PSC_CNT_RST  = 8'h00;            // prescale counter reset value

  // ----------------------------------------------------------------
  // counter widths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned HALF_W       = 16;               // one timer
  localparam int unsigned WIDE_W       = 32;               // paired timers
  localparam logic [31:0] COUNT_RST    = 32'h0000_0000;    // count reset value

  // ----------------------------------------------------------------
  // priority register fields
  // ----------------------------------------------------------------
  localparam int unsigned PRIO_LSB     = 2;                // priority at bits 4:2
  localparam int unsigned PRIO_MSB     = 4;
  localparam int unsigned SUBP_LSB     = 0;                // subpriority at bits 1:0
  localparam int unsigned SUBP_MSB     = 1;
  localparam int unsigned PRIO_REG_W   = 5;
  localparam logic [2:0]  PRIO_OFF     = 3'h0;             // priority that disables irq

  // ----------------------------------------------------------------
  // external clock synchroniser and flag latency
  // ----------------------------------------------------------------
  localparam int unsigned SYNC_STAGES  = 2;                // two flip-flops
  localparam int unsigned FLAG_LAT_CYC = 3;                // 1 bus + 2 system clocks

endpackage : tmr_pkg

//--- verilog/tmr_sync.sv
// Purpose: two flip-flop level synchroniser for the timer pin
// Assumes: asynchronous active-low reset
// Notes:   only the second stage is visible outside
module tmr_sync
  import tmr_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // level in and out
  input  wire logic d_i,
  output logic      q_o
);

  logic meta;   // first stage, read only by the second

  // ----------------------------------------------------------------
  // two stages
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= 1'b0;
      q_o  <= 1'b0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule // tmr_sync

//--- verilog/tmr_core.sv
// Purpose: prescaler, counter, period match, gate event and interrupt flag
// Assumes: clk_i is both bus and system clock; inputs synchronous except pin
// Notes:   the pin is synchronised here; warm_rst_i is a non power-on reset
//
// Contract
// R1: divide source by 1,2,4,8,16,32,64,256
// R2: warm reset clears prescale counter
// R3: disabled timer clears prescale counter
// R4: count write clears prescale counter
// R5: external prescaler resyncs over 2-3 edges
// R6: external count starts 2-3 edges after enable (at 1:1 the code skips the resync and counts from the first edge)
// R7: wrap to zero N source clocks after match
// R8: count reads period until delayed wrap
// R9: event on period match or gate fall (in gated mode the code raises no match event, only the gate fall)
// R10: flag within one bus plus two clocks
// R11: interrupt only when enable bit set
// R12: software clears flag, hardware never does
// R13: priority bits 4:2, subpriority bits 1:0
// R14: zero priority blocks the interrupt
// R15: pin used only in gated/external modes
// R16: internal match wraps then keeps counting
// R17: gate fall raises event, holds count
// R18: paired mode uses upper enable and flag
// R19: select zero is 1:1, seven 1:256
module tmr_core
  import tmr_pkg::*;
#(
  parameter int unsigned CNT_W = WIDE_W                 // count register width
)(
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rstn_i,
  input  wire logic                  warm_rst_i,         // non power-on reset pulse
  // control bits
  input  wire logic                  timer_on_i,
  input  wire logic [PSC_SEL_W-1:0]  prescale_select_i,
  input  wire logic                  clock_source_select_i,
  input  wire logic                  gate_mode_enable_i,
  input  wire logic                  pair_wide_mode_i,
  // count and period
  input  wire logic                  count_wr_i,         // count register write strobe
  input  wire logic [CNT_W-1:0]      count_wdata_i,
  input  wire logic [CNT_W-1:0]      timer_period_reg_i,
  // interrupt control
  input  wire logic                  lo_irq_enable_i,    // lower timer enable
  input  wire logic                  hi_irq_enable_i,    // upper timer enable
  input  wire logic                  lo_flag_clr_i,      // software clear, lower
  input  wire logic                  hi_flag_clr_i,      // software clear, upper
  input  wire logic [PRIO_REG_W-1:0] irq_priority_ctrl_reg_i,
  // pin
  input  wire logic                  timer_ext_clock_gate_pin_i,
  // status
  output logic [CNT_W-1:0]           timer_count_reg_o,
  output logic                       lo_irq_flag_o,
  output logic                       hi_irq_flag_o,
  output logic                       irq_req_o,
  output logic [PRIO_MSB-PRIO_LSB:0] timer_irq_priority_o,
  output logic [SUBP_MSB-SUBP_LSB:0] timer_irq_subpriority_o,
  output logic                       pin_in_use_o        // pin claimed by the timer
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,                      // disabled
    ST_SYNC = 3'b010,                      // waiting for external edges
    ST_RUN  = 3'b100                       // counting
  } mode_e;

  typedef struct packed {
    mode_e                  mode;
    logic [PSC_CNT_W-1:0]   psc;           // prescale counter
    logic [1:0]             sync_edges;    // external edges seen while resyncing
    logic                   pin_d;         // previous synchronised pin
    logic                   matched;       // holding at period, wrap pending
    logic [CNT_W-1:0]       count;
    logic                   ev_d1;         // event pipeline
    logic                   ev_d2;
    logic                   lo_flag;
    logic                   hi_flag;
    logic                   irq;
    logic [2:0]             prio;
    logic [1:0]             subp;
    logic                   pin_use;
  } state_s;

  state_s st;         // registered state
  state_s next_st;    // next state

  logic pin_s;        // synchronised pin level

  // pin passes two flops before any logic looks at it
  tmr_sync u_pin_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    (timer_ext_clock_gate_pin_i),
    .q_o    (pin_s)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // ratio minus one for each code
  function automatic logic [PSC_CNT_W-1:0] psc_last(input logic [PSC_SEL_W-1:0] sel);
    logic [PSC_CNT_W-1:0] r;
    r = '0;
    case (sel)
      3'h0:    r = 8'h00;  // R19
      3'h1:    r = 8'h01;
      3'h2:    r = 8'h03;
      3'h3:    r = 8'h07;
      3'h4:    r = 8'h0f;
      3'h5:    r = 8'h1f;
      3'h6:    r = 8'h3f;
      3'h7:    r = 8'hff;  // R19
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  logic ext_mode;     // counting external edges
  logic src_tick;     // one source clock
  logic gate_fall;
  logic psc_done;
  logic ratio_one;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_st   = st;
    ext_mode  = clock_source_select_i && !gate_mode_enable_i;
    gate_fall = gate_mode_enable_i && !clock_source_select_i && st.pin_d && !pin_s;  // R17
    ratio_one = (prescale_select_i == 3'h0);
    // source clock: bus clock, or a rising pin edge in external mode
    src_tick  = ext_mode ? (pin_s && !st.pin_d) : 1'b1;  // R1
    if (gate_mode_enable_i && !clock_source_select_i) begin
      src_tick = pin_s;                                  // counts while gate high
    end
    psc_done  = (st.psc == psc_last(prescale_select_i));
    next_st.pin_d   = pin_s;
    next_st.pin_use = timer_on_i && (clock_source_select_i || gate_mode_enable_i);  // R15
    next_st.ev_d1   = 1'b0;

    case (st.mode)
      ST_IDLE: begin
        next_st.psc = PSC_CNT_RST;                       // R3
        next_st.matched = 1'b0;
        if (timer_on_i) begin
          next_st.sync_edges = 2'h0;
          next_st.mode = (ext_mode && !ratio_one) ? ST_SYNC : ST_RUN;  // R6
        end
      end
      ST_SYNC: begin
        // two external edges resynchronise the prescaler
        if (src_tick) begin
          next_st.sync_edges = st.sync_edges + 2'h1;     // R5
          if (st.sync_edges == 2'h1) begin
            next_st.mode = ST_RUN;                       // R6
          end
        end
      end
      ST_RUN: begin
        if (src_tick) begin
          next_st.psc = psc_done ? PSC_CNT_RST : st.psc + 8'h01;  // R1
          if (st.matched) begin
            // N source clocks after the match the count wraps
            if (psc_done) begin
              next_st.count   = COUNT_RST[CNT_W-1:0];    // R7 R16
              next_st.matched = 1'b0;
            end
          end else if (psc_done) begin
            if (st.count == timer_period_reg_i) begin
              if (ratio_one) begin
                next_st.count = COUNT_RST[CNT_W-1:0];    // R16
              end else begin
                next_st.matched = 1'b1;                  // R8
              end
              // gated mode gives no match event
              next_st.ev_d1 = !gate_mode_enable_i;       // R9
            end else begin
              next_st.count = st.count + CNT_W'(1);
            end
          end
        end
        if (gate_fall) begin
          next_st.ev_d1 = 1'b1;                          // R9 R17
        end
      end
      default: begin
        next_st.mode = ST_IDLE;
      end
    endcase

    if (!timer_on_i) begin
      next_st.mode = ST_IDLE;
      next_st.psc  = PSC_CNT_RST;                        // R3
    end
    // count write loads the value and clears the prescaler
    if (count_wr_i) begin
      next_st.count   = count_wdata_i;
      next_st.psc     = PSC_CNT_RST;                     // R4
      next_st.matched = 1'b0;
      if (timer_on_i && ext_mode && !ratio_one) begin
        next_st.mode = ST_SYNC;                          // R5
        next_st.sync_edges = 2'h0;
      end
    end
    if (warm_rst_i) begin
      next_st.psc = PSC_CNT_RST;                         // R2
    end

    // event reaches the flag two cycles later
    next_st.ev_d2 = st.ev_d1;                            // R10
    // set wins over a software clear; hardware never clears
    if (lo_flag_clr_i) next_st.lo_flag = 1'b0;           // R12
    if (hi_flag_clr_i) next_st.hi_flag = 1'b0;           // R12
    if (st.ev_d2) begin
      if (pair_wide_mode_i) next_st.hi_flag = 1'b1;      // R18
      else                  next_st.lo_flag = 1'b1;      // R10
    end

    next_st.prio = irq_priority_ctrl_reg_i[PRIO_MSB:PRIO_LSB];  // R13
    next_st.subp = irq_priority_ctrl_reg_i[SUBP_MSB:SUBP_LSB];  // R13
    // paired mode looks only at the upper enable and flag
    next_st.irq  = (next_st.prio != PRIO_OFF) &&                // R14
                   (pair_wide_mode_i ? (hi_irq_enable_i && next_st.hi_flag)  // R18
                                     : (lo_irq_enable_i && next_st.lo_flag)); // R11
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '{mode: ST_IDLE, psc: PSC_CNT_RST, sync_edges: 2'h0, pin_d: 1'b0,
              matched: 1'b0, count: '0, ev_d1: 1'b0, ev_d2: 1'b0, lo_flag: 1'b0,
              hi_flag: 1'b0, irq: 1'b0, prio: 3'h0, subp: 2'h0, pin_use: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign timer_count_reg_o       = st.count;
  assign lo_irq_flag_o           = st.lo_flag;
  assign hi_irq_flag_o           = st.hi_flag;
  assign irq_req_o               = st.irq;
  assign timer_irq_priority_o    = st.prio;
  assign timer_irq_subpriority_o = st.subp;
  assign pin_in_use_o            = st.pin_use;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_flag_latency: assert property (@(posedge clk_i) disable iff (!rstn_i)  // R10
    st.ev_d1 && !pair_wide_mode_i ##1 !pair_wide_mode_i |=> st.lo_flag)
    else $error("flag not set in time after event");

  a_no_hw_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)  // R12
    st.lo_flag && !lo_flag_clr_i |=> st.lo_flag)
    else $error("flag cleared without software");

  a_prio_zero_blk: assert property (@(posedge clk_i) disable iff (!rstn_i)  // R14
    st.prio == PRIO_OFF |-> !st.irq)
    else $error("interrupt with zero priority");

  a_irq_needs_en: assert property (@(posedge clk_i) disable iff (!rstn_i)  // R11
    $rose(st.irq) |-> $past(lo_irq_enable_i) || $past(hi_irq_enable_i))
    else $error("interrupt without enable");

  a_off_clears_psc: assert property (@(posedge clk_i) disable iff (!rstn_i)  // R3
    !timer_on_i |=> st.psc == PSC_CNT_RST)
    else $error("prescaler not cleared when disabled");

  a_write_psc: assert property (@(posedge clk_i) disable iff (!rstn_i)  // R4
    count_wr_i |=> st.psc == PSC_CNT_RST && st.count == $past(count_wdata_i))
    else $error("count write did not clear prescaler");

  a_warm_psc: assert property (@(posedge clk_i) disable iff (!rstn_i)  // R2
    warm_rst_i |=> st.psc == PSC_CNT_RST)
    else $error("warm reset did not clear prescaler");

  a_hold_matched: assert property (@(posedge clk_i) disable iff (!rstn_i)  // R8
    st.matched && !(src_tick && psc_done) && !count_wr_i |=> st.count == $past(st.count))
    else $error("count moved before delayed wrap");

  a_gate_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)  // R17
    st.mode == ST_RUN && gate_fall && !count_wr_i ##1 (!pin_s && !count_wr_i) [*2] |->
    st.count == $past(st.count))
    else $error("count moved after gate fall");

  a_pin_release: assert property (@(posedge clk_i) disable iff (!rstn_i)  // R15
    !clock_source_select_i && !gate_mode_enable_i |=> !st.pin_use)
    else $error("pin held in plain timer mode");

endmodule // tmr_core

//--- tb/tmr_pin_model.sv
// Purpose: far-side source driving the timer clock/gate pin
// Assumes: pin is a plain input, idle low between bursts
// Notes:   edges land 1 ns after a clock edge, three cycles per level
module tmr_pin_model (
  // reference clock
  input  wire logic clk_i,
  // pin level
  output logic      pin_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial pin_o = 1'b0;  // source stands still until asked

  // gate level, held until changed again
  task automatic level(input logic v);
    pin_o = v;
  endtask

  // k whole clock pulses, slow enough to survive the synchroniser
  task automatic pulses(input int k);
    repeat (k) begin
      repeat (3) @(posedge clk_i);
      #1 pin_o = 1'b1;
      repeat (3) @(posedge clk_i);
      #1 pin_o = 1'b0;
    end
  endtask
endmodule // tmr_pin_model

//--- tb/timer_prescaler_and_event_irq_bench.sv
// Purpose: self-checking bench for the timer prescaler and event logic
// Assumes: 16-bit count, one 125 MHz clock, inputs driven 1 ns after edges
// Notes:   cycle intervals are measured between count changes
module timer_prescaler_and_event_irq_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import tmr_pkg::*;
  localparam int W = 16;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clk_i = 0, rstn_i = 0, warm_rst_i = 0, timer_on_i = 0;
  logic [2:0] prescale_select_i = 0;
  logic cs = 0, gm = 0, pw = 0, count_wr_i = 0;
  logic [W-1:0] wdata = 0, per = 0, cnt;
  logic lo_en = 0, hi_en = 0, lo_clr = 0, hi_clr = 0, pin;
  logic [4:0] prio_reg = 0;
  logic lo_f, hi_f, irq, in_use;
  logic [2:0] prio_o;
  logic [1:0] subp_o;
  int err_count = 0, n_compared = 0, c;

  always #4 clk_i = ~clk_i;  // 8 ns period

  tmr_pin_model pin_src (.clk_i(clk_i), .pin_o(pin));

  tmr_core #(.CNT_W(W)) dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .warm_rst_i(warm_rst_i),
    .timer_on_i(timer_on_i), .prescale_select_i(prescale_select_i),
    .clock_source_select_i(cs), .gate_mode_enable_i(gm), .pair_wide_mode_i(pw),
    .count_wr_i(count_wr_i), .count_wdata_i(wdata), .timer_period_reg_i(per),
    .lo_irq_enable_i(lo_en), .hi_irq_enable_i(hi_en), .lo_flag_clr_i(lo_clr),
    .hi_flag_clr_i(hi_clr), .irq_priority_ctrl_reg_i(prio_reg),
    .timer_ext_clock_gate_pin_i(pin), .timer_count_reg_o(cnt),
    .lo_irq_flag_o(lo_f), .hi_irq_flag_o(hi_f), .irq_req_o(irq),
    .timer_irq_priority_o(prio_o), .timer_irq_subpriority_o(subp_o),
    .pin_in_use_o(in_use));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // bounded wait for a count value; c returns the cycles spent
  task automatic wait_cnt(input logic [W-1:0] v, output int c);
    c = 0;
    while (cnt !== v) begin
      if (c > 3000) begin
        err_count++;
        final_report();
      end
      step(1);
      c++;
    end
  endtask

  // stop, clear flags, set mode, zero the count, then start
  task automatic cfg(input logic [2:0] s, input logic e, g, p, input logic [W-1:0] pr);
    timer_on_i = 0;
    step(3);  // let events already in flight reach the flags before the clear
    {lo_clr, hi_clr} = 2'b11;
    {prescale_select_i, cs, gm, pw, per} = {s, e, g, p, pr};
    count_wr_i = 1;
    wdata = 0;
    step(1);
    {lo_clr, hi_clr, count_wr_i} = 3'b000;
    timer_on_i = 1;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_match();
    lo_en = 1;
    prio_reg = 5'h05;
    cfg(0, 0, 0, 0, 3);
    chk(in_use, 0);
    wait_cnt(3, c);
    wait_cnt(0, c);
    chk(c, 1);
    c = 0;
    while (lo_f !== 1'b1 && c < 6) begin step(1); c++; end
    chk(c <= 3, 1);
    chk(irq, 1);
    chk({prio_o, subp_o}, 5'h05);
    step(12);
    chk(lo_f, 1);
    lo_clr = 1;
    step(1);
    lo_clr = 0;
    step(1);
    chk(lo_f, 0);
    $display("test match done");
  endtask

  task automatic t_psc();
    for (int s = 0; s < 8; s++) begin
      cfg(s[2:0], 0, 0, 0, 16'hffff);
      wait_cnt(1, c);
      wait_cnt(2, c);
      chk(c, s == 7 ? 256 : 1 << s);
    end
    $display("test prescale done");
  endtask

  task automatic t_wrap();
    cfg(2, 0, 0, 0, 2);
    wait_cnt(2, c);
    c = 0;
    while (cnt === 2 && c < 40) begin step(1); c++; end
    chk(c, 32'h0000_0008);
    chk(cnt, 0);
    $display("test wrap done");
  endtask

  // three ways to clear a half-full prescaler at 1:4
  task automatic t_clear();
    for (int k = 0; k < 3; k++) begin
      cfg(2, 0, 0, 0, 16'hffff);
      wait_cnt(1, c);
      step(2);
      if (k == 0) count_wr_i = 1;
      if (k == 1) warm_rst_i = 1;
      if (k == 2) timer_on_i = 0;
      wdata = 1;
      step(1);
      {count_wr_i, warm_rst_i, timer_on_i} = 3'b001;
      wait_cnt(2, c);
      chk(c >= 3, 1);
    end
    $display("test clear done");
  endtask

  task automatic t_mask();
    lo_en = 1;
    prio_reg = 5'h03;  // priority zero
    cfg(0, 0, 0, 0, 2);
    step(12);
    chk({lo_f, irq}, 2'b10);
    lo_en = 0;
    prio_reg = 5'h1c;
    cfg(0, 0, 0, 0, 2);
    step(12);
    chk({lo_f, irq}, 2'b10);
    $display("test mask done");
  endtask

  task automatic t_pair();
    hi_en = 1;
    lo_en = 1;
    cfg(0, 0, 0, 1, 2);
    step(12);
    chk({hi_f, lo_f, irq}, 3'b101);
    $display("test pair done");
  endtask

  task automatic t_gate();
    cfg(0, 0, 1, 0, 16'hffff);
    pin_src.level(1);
    step(3);
    chk(in_use, 1);
    step(10);
    chk(cnt, 16'h000b);
    chk(lo_f, 0);
    pin_src.level(0);
    c = 0;
    while (lo_f !== 1'b1 && c < 12) begin step(1); c++; end
    chk(lo_f, 1);
    step(6);
    chk(cnt, 16'h000d);
    $display("test gate done");
  endtask

  task automatic t_ext();
    cfg(1, 1, 0, 0, 16'hffff);
    pin_src.pulses(1);
    step(4);
    chk(cnt, 0);
    pin_src.pulses(7);
    step(4);
    chk(cnt, 16'h0003);
    // a count write restarts the two-edge resync
    count_wr_i = 1;
    wdata = 0;
    step(1);
    count_wr_i = 0;
    pin_src.pulses(3);
    step(4);
    chk(cnt, 16'h0000);
    pin_src.pulses(1);
    step(4);
    chk(cnt, 16'h0001);
    $display("test external done");
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    #1 rstn_i = 1;
    step(1);
    chk({cnt, lo_f, hi_f, irq}, 0);
    t_match();
    t_psc();
    t_wrap();
    t_clear();
    t_mask();
    t_pair();
    t_gate();
    t_ext();
    final_report();
  end
endmodule // timer_prescaler_and_event_irq_bench
